// ---- core/gsp_consts.vh ----
// Constants shared by the angular-rate sensor serial slave port.
`ifndef GSP_CONSTS_VH
`define GSP_CONSTS_VH
`define GSP_WORD_BITS        16
`define GSP_FAST_MAX_PERIOD  8'h07
`define GSP_PERIOD_RESET     8'h01
`define GSP_CLK_MHZ          125
`define GSP_STARTUP_US       20
`define GSP_STARTUP_CYCLES   (`GSP_STARTUP_US * `GSP_CLK_MHZ)
`define GSP_WAKE_US          25
`define GSP_WAKE_CYCLES      (`GSP_WAKE_US * `GSP_CLK_MHZ)
`define GSP_CMD_PERIOD       8'hB6
`endif

// ---- core/gsp_sync.v ----
// Two-stage synchroniser for a group of asynchronous pin inputs.
`timescale 1ns/1ps
module gsp_sync #(
    parameter WIDTH = 1,
    parameter [WIDTH-1:0] INIT = {WIDTH{1'b0}}
) (
    input  wire             clk,
    input  wire             ce,
    input  wire             srst,
    input  wire [WIDTH-1:0] d,
    output wire [WIDTH-1:0] q
);
    reg [WIDTH-1:0] meta_reg;
    reg [WIDTH-1:0] sync_reg;

    // The first stage is read only by the second one.
    always @(posedge clk) begin
        if (srst) begin
            meta_reg <= INIT;
            sync_reg <= INIT;
        end else if (ce) begin
            meta_reg <= d;
            sync_reg <= meta_reg;
        end
    end

    assign q = sync_reg;
endmodule

// ---- core/gsp_spi_port.v ----
// Serial slave port of the angular-rate sensor: shifting, modes, sleep.
`timescale 1ns/1ps
`include "gsp_consts.vh"
module gsp_spi_port #(
    parameter WORD_BITS      = `GSP_WORD_BITS,
    parameter STARTUP_CYCLES = `GSP_STARTUP_CYCLES,
    parameter WAKE_CYCLES    = `GSP_WAKE_CYCLES
) (
    input  wire                 I_CLK,
    input  wire                 I_SRST,
    input  wire                 I_CE,
    input  wire                 I_SCLK,
    input  wire                 I_CS_N,
    input  wire                 I_DIN,
    input  wire                 I_RST_N,
    input  wire                 I_SLEEP_REQ,
    input  wire [WORD_BITS-1:0] I_TX_WORD,
    output reg                  O_DOUT,
    output reg                  O_DOUT_OE,
    output reg  [WORD_BITS-1:0] O_RX_WORD,
    output reg                  O_RX_VALID,
    output reg                  O_FAST_MODE,
    output reg  [7:0]           O_SAMPLE_PERIOD,
    output reg                  O_ASLEEP,
    output reg                  O_READY,
    output reg                  O_COND_RESET
);
    localparam CW = 32;
    localparam [1:0] ST_START = 2'h0;
    localparam [1:0] ST_RUN   = 2'h1;
    localparam [1:0] ST_SLEEP = 2'h2;
    localparam [1:0] ST_WAKE  = 2'h3;

    wire       sclk_s;
    wire       cs_n_s;
    wire       din_s;
    wire       rst_n_s;
    reg        sclk_d_reg;
    reg        cs_n_d_reg;
    reg [WORD_BITS-1:0] tx_reg;
    reg [WORD_BITS-1:0] rx_reg;
    reg [4:0]           cnt_reg;
    reg [1:0]           st_reg;
    reg [CW-1:0]        tmr_reg;
    reg                 frame_reg;

    // Pins come from the host's domain, so each passes two flip-flops.
    // The stages reset to the idle pin levels: clock high, select high,
    // data low, reset pin high, so nothing looks like an edge.
    gsp_sync #(.WIDTH(4), .INIT(4'hD)) u_sync (
        .clk  (I_CLK),
        .ce   (I_CE),
        .srst (I_SRST),
        .d    ({I_SCLK, I_CS_N, I_DIN, I_RST_N}),
        .q    ({sclk_s, cs_n_s, din_s, rst_n_s})
    );

    // Edge detection; clock idles high so a fall starts each bit.
    // The history flops reset to the idle levels, so no false edge
    // is seen when the synchroniser leaves reset.
    wire sclk_rise = sclk_s & ~sclk_d_reg;
    wire sclk_fall = ~sclk_s & sclk_d_reg;
    wire cs_fall   = ~cs_n_s & cs_n_d_reg;
    wire cs_active = ~cs_n_s;
    wire port_run  = (st_reg == ST_RUN);
    wire [WORD_BITS-1:0] rx_shift = {rx_reg[WORD_BITS-2:0], din_s};
    wire [7:0]           rx_cmd   = rx_shift[WORD_BITS-1:WORD_BITS-8];
    wire [7:0]           rx_arg   = rx_shift[7:0];

    // History of the synchronised clock and select levels.
    always @(posedge I_CLK) begin
        if (I_SRST) begin
            sclk_d_reg <= 1'b1;
            cs_n_d_reg <= 1'b1;
        end else if (I_CE) begin
            sclk_d_reg <= sclk_s;
            cs_n_d_reg <= cs_n_s;
        end
    end

    // A frame is only accepted when its select fall was seen while the
    // port was running; a word already under way when start-up or wake
    // ends is ignored to its end rather than joined in mid-word.
    always @(posedge I_CLK) begin
        if (I_SRST) begin
            frame_reg <= 1'b0;
        end else if (I_CE) begin
            if (!cs_active || !port_run) begin
                frame_reg <= 1'b0;
            end else if (cs_fall) begin
                frame_reg <= 1'b1;
            end
        end
    end

    // The mode flag trails the stored period by one cycle; the host only
    // looks at it between words, so the extra flop costs nothing.
    always @(posedge I_CLK) begin
        if (I_SRST) begin
            O_FAST_MODE <= 1'b1;
        end else if (I_CE) begin
            O_FAST_MODE <= (O_SAMPLE_PERIOD <= `GSP_FAST_MAX_PERIOD);
        end
    end

    // Shift engine: output moves on falling clock, input on rising clock.
    always @(posedge I_CLK) begin
        if (I_SRST) begin
            tx_reg          <= {WORD_BITS{1'b0}};
            rx_reg          <= {WORD_BITS{1'b0}};
            cnt_reg         <= 5'h00;
            O_DOUT          <= 1'b0;
            O_DOUT_OE       <= 1'b0;
            O_RX_WORD       <= {WORD_BITS{1'b0}};
            O_RX_VALID      <= 1'b0;
            O_SAMPLE_PERIOD <= `GSP_PERIOD_RESET;
        end else if (I_CE) begin
            O_RX_VALID <= 1'b0;
            if (!cs_active || !port_run) begin
                // Released pin; a partial word is dropped here.
                O_DOUT_OE <= 1'b0;
                cnt_reg   <= 5'h00;
            end else if (cs_fall) begin
                // MSB goes out before any clock edge arrives.
                O_DOUT_OE <= 1'b1;
                O_DOUT    <= I_TX_WORD[WORD_BITS-1];
                tx_reg    <= {I_TX_WORD[WORD_BITS-2:0], 1'b0};
                cnt_reg   <= 5'h00;
            end else if (frame_reg) begin
                O_DOUT_OE <= 1'b1;
                // The first falling edge keeps the MSB on the pin, since
                // the host samples it on the rising edge that follows.
                if (sclk_fall && cnt_reg != 5'h00) begin
                    O_DOUT <= tx_reg[WORD_BITS-1];
                    tx_reg <= {tx_reg[WORD_BITS-2:0], 1'b0};
                end
                if (sclk_rise) begin
                    rx_reg <= rx_shift;
                    if (cnt_reg == WORD_BITS[4:0] - 5'h01) begin
                        cnt_reg    <= 5'h00;
                        O_RX_WORD  <= rx_shift;
                        O_RX_VALID <= 1'b1;
                        // A period write command updates the mode.
                        if (rx_cmd == `GSP_CMD_PERIOD) begin
                            O_SAMPLE_PERIOD <= rx_arg;
                        end
                    end else begin
                        cnt_reg <= cnt_reg + 5'h01;
                    end
                end
            end
        end
    end

    // Power state: start-up after reset pin, sleep, wake on select.
    // Words arriving during start-up are ignored rather than queued.
    // A low reset pin wins over every state, as conditioning restarts.
    always @(posedge I_CLK) begin
        if (I_SRST) begin
            st_reg       <= ST_START;
            tmr_reg      <= {CW{1'b0}};
            O_ASLEEP     <= 1'b0;
            O_READY      <= 1'b0;
            O_COND_RESET <= 1'b1;
        end else if (I_CE) begin
            O_COND_RESET <= ~rst_n_s;
            if (!rst_n_s) begin
                st_reg   <= ST_START;
                tmr_reg  <= {CW{1'b0}};
                O_READY  <= 1'b0;
                O_ASLEEP <= 1'b0;
            end else begin
                case (st_reg)
                ST_START: begin
                    tmr_reg <= tmr_reg + 1'b1;
                    if (tmr_reg >= STARTUP_CYCLES - 1) begin
                        st_reg  <= ST_RUN;
                        O_READY <= 1'b1;
                    end
                end
                ST_RUN: begin
                    tmr_reg <= {CW{1'b0}};
                    if (I_SLEEP_REQ && !cs_active) begin
                        st_reg   <= ST_SLEEP;
                        O_ASLEEP <= 1'b1;
                        O_READY  <= 1'b0;
                    end
                end
                ST_SLEEP: begin
                    if (cs_active) begin
                        st_reg   <= ST_WAKE;
                        O_ASLEEP <= 1'b0;
                    end
                end
                ST_WAKE: begin
                    tmr_reg <= tmr_reg + 1'b1;
                    if (tmr_reg >= WAKE_CYCLES - 1 && !cs_active) begin
                        st_reg  <= ST_RUN;
                        O_READY <= 1'b1;
                    end
                end
                default: st_reg <= ST_START;
                endcase
            end
        end
    end
endmodule

// ---- tb/gsp_spi_port_asserts.sv ----
// Pin-level checks for the serial slave port.
`timescale 1ns/1ps
module gsp_spi_port_asserts (
    input wire       I_CLK,
    input wire       I_SRST,
    input wire       I_SCLK,
    input wire       I_CS_N,
    input wire       I_RST_N,
    input wire       O_DOUT,
    input wire       O_DOUT_OE,
    input wire       O_RX_VALID,
    input wire       O_FAST_MODE,
    input wire [7:0] O_SAMPLE_PERIOD,
    input wire       O_ASLEEP,
    input wire       O_READY,
    input wire       O_COND_RESET
);
    // Pins pass a two-flop sync, so answers lag pin edges by three.
    default clocking cb @(posedge I_CLK); endclocking
    default disable iff (I_SRST);
    property p_release; I_CS_N [*4] |-> !O_DOUT_OE; endproperty
    a_release: assert property (p_release) else $error("dout held");
    property p_msb; $fell(I_CS_N) && O_READY |-> ##[2:4] O_DOUT_OE;
    endproperty
    a_msb: assert property (p_msb) else $error("no msb");
    property p_shift; O_DOUT_OE && $past(O_DOUT_OE) && $changed(O_DOUT)
        |-> !$past(I_SCLK, 2); endproperty
    a_shift: assert property (p_shift) else $error("bad shift");
    property p_cap; O_RX_VALID |-> $past(I_SCLK, 2) && !$past(I_CS_N, 2);
    endproperty
    a_cap: assert property (p_cap) else $error("bad capture");
    property p_pulse; O_RX_VALID |=> !O_RX_VALID; endproperty
    a_pulse: assert property (p_pulse) else $error("long valid");
    property p_wake; $fell(I_CS_N) && O_ASLEEP |-> ##[1:5] !O_ASLEEP;
    endproperty
    a_wake: assert property (p_wake) else $error("no wake");
    property p_hw; !I_RST_N [*6] |-> O_COND_RESET && !O_READY; endproperty
    a_hw: assert property (p_hw) else $error("pin reset");
    property p_mode; $changed(O_SAMPLE_PERIOD)
        |=> O_FAST_MODE == (O_SAMPLE_PERIOD <= 8'h07); endproperty
    a_mode: assert property (p_mode) else $error("mode");
endmodule
bind gsp_spi_port gsp_spi_port_asserts u_chk (.*);

// ---- tb/gsp_host_model.sv ----
// Host model: serial master in clock mode three, one word per call.
`timescale 1ns/1ps
module gsp_host_model #(
    parameter real FLASH_WAIT_NS = 50000000.0
) (
    input  wire i_miso,
    input  wire i_fast,
    output reg  o_sclk = 1'b1,
    output reg  o_cs_n = 1'b1,
    output reg  o_mosi = 1'b0
);
    // Sends the top n bits; a short count leaves a partial word.
    task xfer(input [15:0] tx, input integer n, output [15:0] rx);
        integer i;
        begin
            rx = 16'h0000;
            o_cs_n = 1'b0;
            #200;
            for (i = 15; i > 15 - n; i = i - 1) begin
                o_sclk = 1'b0;
                o_mosi = tx[i];
                #62.5;
                o_sclk = 1'b1;
                rx[i] = i_miso;
                #62.5;
            end
            #100;
            o_cs_n = 1'b1;
            o_mosi = ~o_mosi;
            // One wait covers both the stall and the word period.
            #(i_fast ? 32000 : 42000);
        end
    endtask

    // After asking for a flash update the host stays off the port.
    task flash_pause;
        begin
            #(FLASH_WAIT_NS);
        end
    endtask
endmodule

// ---- tb/gyro_spi_slave_port_bench.sv ----
// Bench for the serial slave port against a host model.
`timescale 1ns/1ps
`define CHK(n, e, s) begin compares++; if ((s) !== (e)) begin fails++; \
    $display("[FAIL] %s exp %h got %h", n, e, s); end end
module gyro_spi_slave_port_bench;
    reg         I_CLK = 1'b0;
    reg         I_SRST = 1'b1;
    reg         I_CE = 1'b1;
    reg         I_RST_N = 1'b1;
    reg         I_SLEEP_REQ = 1'b0;
    reg  [15:0] I_TX_WORD = 16'h0000;
    wire        I_SCLK, I_CS_N, I_DIN, O_DOUT, O_DOUT_OE, O_RX_VALID;
    wire        O_FAST_MODE, O_ASLEEP, O_READY, O_COND_RESET;
    wire [15:0] O_RX_WORD;
    wire [7:0]  O_SAMPLE_PERIOD;
    reg  [15:0] got, exp_w, q[$];
    reg  [7:0]  per[4] = '{8'h07, 8'h08, 8'hFF, 8'h00};
    integer     fails = 0, compares = 0, i, k;
    always #4 I_CLK = ~I_CLK;
    // Short start-up counts keep the run brief.
    gsp_spi_port #(.STARTUP_CYCLES(4), .WAKE_CYCLES(4))
        dut (.*);
    // A released line shows the inverse of its last level.
    // The flash pause is shortened like the start-up counts.
    gsp_host_model #(.FLASH_WAIT_NS(2000.0))
        host (.i_miso(O_DOUT_OE ? O_DOUT : ~O_DOUT),
        .i_fast(O_FAST_MODE), .o_sclk(I_SCLK), .o_cs_n(I_CS_N),
        .o_mosi(I_DIN));
    // Each received word must match the oldest noted word.
    always @(negedge I_CLK) if (O_RX_VALID === 1'b1) begin
        exp_w = q.size() ? q.pop_front() : 16'hXXXX;
        `CHK("rx_word", exp_w, O_RX_WORD)
    end
    task conclude;
        begin
            $display("compares %0d fails %0d", compares, fails);
            if (fails == 0 && compares > 0)
                $display("SIMULATION PASSED");
            else
                $display("SIMULATION FAILED");
            $finish;
        end
    endtask
    task wait_ready;
        begin
            for (k = 0; k < 3000 && O_READY !== 1'b1; k++) @(negedge I_CLK);
            `CHK("ready", 1'b1, O_READY)
            if (O_READY !== 1'b1) conclude;
        end
    endtask
    task word(input [15:0] t, input [15:0] r);
        begin
            @(negedge I_CLK);
            I_TX_WORD = t;
            q.push_back(r);
            host.xfer(r, 16, got);
            `CHK("dout_word", t, got)
        end
    endtask
    initial begin
        k = $urandom(38);
        repeat (20) @(negedge I_CLK);
        I_SRST = 1'b0;
        `CHK("period_rst", 8'h01, O_SAMPLE_PERIOD)
        wait_ready;
        for (i = 0; i < 4; i++) begin
            word(16'($urandom), {8'hB6, per[i]});
            `CHK("period", per[i], O_SAMPLE_PERIOD)
            `CHK("fast", per[i] <= 8'h07, O_FAST_MODE)
        end
        // Stands in for the pause after a flash update request.
        host.flash_pause;
        // A partial word is dropped, so nothing is noted for it.
        host.xfer(16'hB612, 9, got);
        `CHK("partial", 8'h00, O_SAMPLE_PERIOD)
        // A low clock enable must hold off the sleep request.
        @(negedge I_CLK);
        I_CE = 1'b0;
        I_SLEEP_REQ = 1'b1;
        repeat (8) @(negedge I_CLK);
        `CHK("frozen", 1'b0, O_ASLEEP)
        I_CE = 1'b1;
        repeat (8) @(negedge I_CLK);
        I_SLEEP_REQ = 1'b0;
        `CHK("asleep", 1'b1, O_ASLEEP)
        host.xfer(16'hB620, 16, got);
        `CHK("woke", 1'b0, O_ASLEEP)
        `CHK("refused", 8'h00, O_SAMPLE_PERIOD)
        wait_ready;
        @(negedge I_CLK);
        I_RST_N = 1'b0;
        repeat (8) @(negedge I_CLK);
        `CHK("cond_rst", 1'b1, O_COND_RESET)
        `CHK("not_ready", 1'b0, O_READY)
        I_RST_N = 1'b1;
        wait_ready;
        word(16'($urandom), 16'($urandom));
        `CHK("queue", 0, q.size())
        conclude;
    end
endmodule
